// >>> inc/dfs_pkg.sv
// Package with timing constants and state encodings for the driver fault and sleep supervisor.
package dfs_pkg;
    localparam int CLK_MHZ              = 100;
    localparam int OCP_QUAL_NS          = 3000;
    localparam int OCP_QUAL_CYC         = (OCP_QUAL_NS * CLK_MHZ + 999) / 1000;
    localparam int RETRY_NS             = 4000000;
    localparam int RETRY_CYC            = (RETRY_NS * CLK_MHZ + 999) / 1000;
    localparam int SLEEP_ENTRY_NS       = 120000;
    localparam int SLEEP_ENTRY_CYC      = (SLEEP_ENTRY_NS * CLK_MHZ + 999) / 1000;
    localparam int WAKEUP_NS            = 1000000;
    localparam int WAKEUP_CYC           = (WAKEUP_NS * CLK_MHZ + 999) / 1000;
    localparam int RESET_PULSE_MIN_NS   = 20000;
    localparam int RESET_PULSE_MIN_CYC  = (RESET_PULSE_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int RESET_PULSE_MAX_NS   = 120000;
    localparam int RESET_PULSE_MAX_CYC  = (RESET_PULSE_MAX_NS * CLK_MHZ) / 1000;
    localparam int NUM_BRIDGES          = 4;
    localparam int CNT_W                = 24;

    typedef enum logic [3:0] {
        PWR_SLEEP  = 4'h1,
        PWR_WAKE   = 4'h2,
        PWR_RUN    = 4'h4,
        PWR_ENTER  = 4'h8
    } dfs_pwr_type;
endpackage

// >>> verification/dfs_ctrl_model.sv
// Controller model that drives the sleep and recovery pins and watches the fault line.
`timescale 1ns/1ps
module dfs_ctrl_model #(
    parameter int WAKE_CYC = 10
) (
    // Clock.
    input  wire logic clock_in,
    // Open-drain fault pin of the driver.
    input  wire logic fault_indicator_low_in,
    input  wire logic fault_indicator_low_oe_n_in,
    // Controller pins and the resolved fault line.
    output logic      sleep_request_low_out,
    output logic      fault_recovery_select_out,
    output wire logic fault_line_out
);
    // The line has a pull-up, so it reads high whenever the driver lets go of it.
    assign fault_line_out = fault_indicator_low_oe_n_in ? 1'h1 : fault_indicator_low_in;

    initial begin
        sleep_request_low_out     = 1'h1;
        fault_recovery_select_out = 1'h1;
    end

    task automatic set_mode(input logic auto_mode);
        @(negedge clock_in);
        fault_recovery_select_out = auto_mode;
    endtask

    // Holds the sleep pin low for a number of cycles; short lows act as a fault reset pulse.
    task automatic low_for(input int cycles);
        @(negedge clock_in);
        sleep_request_low_out = 1'h0;
        repeat (cycles) @(negedge clock_in);
        sleep_request_low_out = 1'h1;
    endtask

    // Waits out the wake-up delay plus two cycles before returning.
    task automatic wake_wait();
        repeat (WAKE_CYC + 2) @(negedge clock_in);
    endtask
endmodule

// >>> verification/driver_fault_sleep_supervisor_tb.sv
// Self-checking bench for the driver fault and sleep supervisor.
`timescale 1ns/1ps
module driver_fault_sleep_supervisor_tb;
    import dfs_pkg::*;
    localparam int QUAL = OCP_QUAL_CYC;
    localparam int WAKE = 10;
    typedef struct packed {
        logic       lockout;
        logic       pump_uv;
        logic       therm;
        logic [3:0] hs;
        logic [3:0] ls;
        logic [3:0] exp_br;
        logic       exp_pump;
        logic       exp_fault;
    } dfs_tb_row_type;
    logic           clock_in = 1'h0;
    logic           sys_rst_in = 1'h1;
    logic           lockout = 1'h0;
    logic           pump_uv = 1'h0;
    logic           logic_uv = 1'h0;
    logic           therm = 1'h0;
    logic [3:0]     hs = 4'h0;
    logic [3:0]     ls = 4'h0;
    logic           sleep_n;
    logic           sel;
    logic           fault_line;
    logic [3:0]     br;
    logic           pump;
    logic           reg_en;
    logic           ser_en;
    logic           ready;
    logic           f_out;
    logic           f_oe_n;
    int             errors = 0;
    int             check_count = 0;
    int             cycles = 0;
    dfs_tb_row_type rows [11];

    dfs_supervisor #(.RETRY_CYC(20), .SLEEP_ENTRY_CYC(200),
        .WAKEUP_CYC(WAKE), .PULSE_MIN_CYC(5), .PULSE_MAX_CYC(12)) dfs_supervisor_inst (
        .clock_in(clock_in), .sys_rst_in(sys_rst_in), .sleep_request_low_in(sleep_n),
        .fault_recovery_select_in(sel), .supply_lockout_in(lockout),
        .pump_undervoltage_in(pump_uv), .logic_undervoltage_in(logic_uv),
        .thermal_shutdown_in(therm), .hs_limit_in(hs), .ls_limit_in(ls),
        .bridge_enable_out(br), .pump_enable_out(pump), .regulator_enable_out(reg_en),
        .serial_enable_out(ser_en), .ready_out(ready), .fault_indicator_low_out(f_out),
        .fault_indicator_low_oe_n_out(f_oe_n));

    dfs_ctrl_model dfs_ctrl_model_inst (
        .clock_in(clock_in), .fault_indicator_low_in(f_out),
        .fault_indicator_low_oe_n_in(f_oe_n), .sleep_request_low_out(sleep_n),
        .fault_recovery_select_out(sel), .fault_line_out(fault_line));

    initial begin
        forever #5 clock_in = ~clock_in;
    end

    always @(posedge clock_in) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        if (errors == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check_bit(input string name, input logic exp, input logic got);
        check_count = check_count + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("ERROR %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic check_vec(input string name, input logic [3:0] exp, input logic [3:0] got);
        check_count = check_count + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clock_in);
    endtask

    task automatic check_state(input logic [3:0] eb, input logic ep, input logic ef);
        check_vec("bridge_enable", eb, br);
        check_bit("pump_enable", ep, pump);
        check_bit("fault_line", ef, fault_line);
    endtask

    initial begin
        rows = '{'{1'h0, 1'h0, 1'h0, 4'h0, 4'h0, 4'hF, 1'h1, 1'h1},
                 '{1'h1, 1'h0, 1'h0, 4'h0, 4'h0, 4'h0, 1'h0, 1'h0},
                 '{1'h0, 1'h0, 1'h0, 4'h0, 4'h0, 4'hF, 1'h1, 1'h1},
                 '{1'h0, 1'h1, 1'h0, 4'h0, 4'h0, 4'h0, 1'h1, 1'h0},
                 '{1'h0, 1'h0, 1'h0, 4'h0, 4'h0, 4'hF, 1'h1, 1'h1},
                 '{1'h0, 1'h0, 1'h1, 4'h0, 4'h0, 4'h0, 1'h0, 1'h0},
                 '{1'h0, 1'h0, 1'h0, 4'h0, 4'h0, 4'hF, 1'h1, 1'h1},
                 '{1'h0, 1'h0, 1'h0, 4'hE, 4'h0, 4'h1, 1'h1, 1'h0},
                 '{1'h0, 1'h0, 1'h0, 4'h0, 4'h0, 4'hF, 1'h1, 1'h1},
                 '{1'h0, 1'h0, 1'h0, 4'h0, 4'h7, 4'h8, 1'h1, 1'h0},
                 '{1'h0, 1'h0, 1'h0, 4'h0, 4'h0, 4'hF, 1'h1, 1'h1}};
        tick(10);
        check_bit("fault_line", 1'h1, fault_line);
        sys_rst_in = 1'h0;
        tick(WAKE - 2);
        check_bit("ready", 1'h0, ready);
        tick(6);
        check_bit("ready", 1'h1, ready);
        foreach (rows[i]) begin
            lockout = rows[i].lockout;
            pump_uv = rows[i].pump_uv;
            therm   = rows[i].therm;
            hs      = rows[i].hs;
            ls      = rows[i].ls;
            tick(QUAL + 40);
            check_state(rows[i].exp_br, rows[i].exp_pump, rows[i].exp_fault);
        end
        // Limit bursts no longer than the qualification time never trip.
        for (int i = 0; i < 5; i++) begin
            hs = 4'h1;
            tick(QUAL);
            hs = 4'h0;
            tick(1);
        end
        check_state(4'hF, 1'h1, 1'h1);
        hs = 4'h1;
        tick(QUAL - 1);
        check_vec("bridge_enable", 4'hF, br);
        tick(4);
        check_state(4'hE, 1'h1, 1'h0);
        hs = 4'h0;
        tick(5);
        check_state(4'hE, 1'h1, 1'h0);
        tick(35);
        check_state(4'hF, 1'h1, 1'h1);
        // Latched overcurrent, a too-short pulse, then a valid reset pulse.
        dfs_ctrl_model_inst.set_mode(1'h0);
        ls = 4'h8;
        tick(QUAL + 5);
        ls = 4'h0;
        tick(40);
        check_state(4'h7, 1'h1, 1'h0);
        dfs_ctrl_model_inst.low_for(3);
        tick(4);
        check_state(4'h7, 1'h1, 1'h0);
        fork
            dfs_ctrl_model_inst.low_for(8);
            begin
                tick(6);
                check_bit("pump_enable", 1'h1, pump);
            end
        join
        tick(4);
        check_state(4'hF, 1'h1, 1'h1);
        // Latched thermal shutdown, an over-long pulse, then a long valid pulse.
        therm = 1'h1;
        tick(4);
        therm = 1'h0;
        tick(40);
        check_state(4'h0, 1'h0, 1'h0);
        dfs_ctrl_model_inst.low_for(16);
        tick(4);
        check_state(4'h0, 1'h0, 1'h0);
        dfs_ctrl_model_inst.low_for(10);
        tick(14);
        check_state(4'hF, 1'h1, 1'h1);
        // Sleep entry, sleep state and wake-up.
        dfs_ctrl_model_inst.set_mode(1'h1);
        fork
            dfs_ctrl_model_inst.low_for(220);
            begin
                tick(150);
                check_bit("pump_enable", 1'h1, pump);
                tick(60);
                check_state(4'h0, 1'h0, 1'h1);
                check_bit("regulator_enable", 1'h0, reg_en);
                check_bit("serial_enable", 1'h0, ser_en);
            end
        join
        tick(2);
        check_bit("ready", 1'h0, ready);
        dfs_ctrl_model_inst.wake_wait();
        check_bit("ready", 1'h1, ready);
        check_state(4'hF, 1'h1, 1'h1);
        lockout = 1'h1;
        tick(4);
        check_bit("ready", 1'h0, ready);
        lockout = 1'h0;
        tick(20);
        check_bit("ready", 1'h1, ready);
        // Logic supply loss clears a latched fault silently.
        dfs_ctrl_model_inst.set_mode(1'h0);
        therm = 1'h1;
        tick(4);
        therm = 1'h0;
        logic_uv = 1'h1;
        tick(2);
        check_state(4'h0, 1'h0, 1'h1);
        logic_uv = 1'h0;
        tick(20);
        check_state(4'hF, 1'h1, 1'h1);
        report_and_stop();
    end
endmodule

// >>> verilog/dfs_oc_channel.sv
// One half-bridge overcurrent qualifier with latched or automatic-retry recovery.
`timescale 1ns/1ps
module dfs_oc_channel #(
    parameter int QUAL_CYC  = dfs_pkg::OCP_QUAL_CYC,
    parameter int RETRY_CYC = dfs_pkg::RETRY_CYC
) (
    // Clock and reset.
    input  wire logic clock_in,
    input  wire logic sys_rst_in,
    // Current limit of either transistor of the bridge.
    input  wire logic hs_limit_in,
    input  wire logic ls_limit_in,
    // Recovery control.
    input  wire logic auto_retry_in,
    input  wire logic clear_in,
    // Fault state of this bridge.
    output logic      fault_out
);
    import dfs_pkg::*;

    if (QUAL_CYC < 1 || RETRY_CYC < 1 ||
        QUAL_CYC >= 2**CNT_W || RETRY_CYC >= 2**CNT_W) begin : g_bad_counts
        $error("dfs_oc_channel: counts out of range");
    end

    logic             limit;
    logic [CNT_W-1:0] qual_q, qual_d;
    logic [CNT_W-1:0] retry_q, retry_d;
    logic             fault_q, fault_d;

    assign limit = hs_limit_in | ls_limit_in; // see R8

    always_comb begin
        qual_d  = qual_q;
        retry_d = retry_q;
        fault_d = fault_q;
        // Qualification restarts whenever the limit drops out.
        if (!limit) begin
            qual_d = '0;
        end else if (qual_q < CNT_W'(QUAL_CYC)) begin
            qual_d = qual_q + 1'b1;
        end
        if (!fault_q) begin
            retry_d = '0;
            if (limit && qual_q >= CNT_W'(QUAL_CYC)) begin
                fault_d = 1'b1; // see R6
            end
        end else begin
            if (retry_q < CNT_W'(RETRY_CYC)) begin
                retry_d = retry_q + 1'b1;
            end
            if (auto_retry_in && retry_q >= CNT_W'(RETRY_CYC) && !limit) begin
                fault_d = 1'b0; // see R10
            end else if (!auto_retry_in && clear_in) begin
                fault_d = 1'b0; // see R9
            end
        end
    end

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            qual_q  <= '0;
            retry_q <= '0;
            fault_q <= 1'b0;
        end else begin
            qual_q  <= qual_d;
            retry_q <= retry_d;
            fault_q <= fault_d;
        end
    end

    assign fault_out = fault_q;

    chk_oc_qualify: assert property (@(posedge clock_in) disable iff (sys_rst_in) // see R6
        (!fault_q && !limit) |=> !fault_q) else $error("overcurrent set without limit");
    chk_oc_latch: assert property (@(posedge clock_in) disable iff (sys_rst_in) // see R9
        (fault_q && !auto_retry_in && !clear_in) |=> fault_q) else $error("latched fault lost");
    chk_oc_retry: assert property (@(posedge clock_in) disable iff (sys_rst_in) // see R10
        (fault_q && auto_retry_in && retry_q < CNT_W'(RETRY_CYC)) |=> fault_q)
        else $error("retry too early");
    cov_oc_fault: cover property (@(posedge clock_in) disable iff (sys_rst_in) $rose(fault_q));
endmodule

// >>> verilog/dfs_supervisor.sv
// Top of the driver fault and sleep supervisor: faults, sleep, wake and reset pulse decode.
`timescale 1ns/1ps
// Function
// R1 - Motor undervoltage: outputs off, fault, pump off
// R2 - Motor supply recovered: resume, release fault
// R3 - Pump undervoltage: outputs off, fault, pump runs
// R4 - Pump undervoltage gone: resume automatically
// R5 - Logic supply low: all off, reset, silent
// R6 - Overcurrent only after qualification time
// R7 - Overcurrent disables only its bridge
// R8 - High or low side limit counts
// R9 - Latched overcurrent held until reset pulse
// R10 - Auto mode restores after retry delay
// R11 - Thermal shutdown: all off, fault, pump off
// R12 - Latched thermal held until reset pulse
// R13 - Auto mode resumes when temperature falls
// R14 - Fault low while fault, released after reset
// R15 - Sleep disables outputs, regulator, interface, pump
// R16 - Sleep entered after entry delay
// R17 - Wake on high; wait wake-up delay
// R18 - Operate only awake with motor supply good
// R19 - Pulse of 20 to 40 us clears faults
// R20 - Pulse of 40 to 120 us clears faults
// R21 - Reset pulse leaves pump and blocks alone
// R22 - Fault output ORs all but logic undervoltage
module dfs_supervisor #(
    parameter int NUM_BR          = dfs_pkg::NUM_BRIDGES,
    parameter int QUAL_CYC        = dfs_pkg::OCP_QUAL_CYC,
    parameter int RETRY_CYC       = dfs_pkg::RETRY_CYC,
    parameter int SLEEP_ENTRY_CYC = dfs_pkg::SLEEP_ENTRY_CYC,
    parameter int WAKEUP_CYC      = dfs_pkg::WAKEUP_CYC,
    parameter int PULSE_MIN_CYC   = dfs_pkg::RESET_PULSE_MIN_CYC,
    parameter int PULSE_MAX_CYC   = dfs_pkg::RESET_PULSE_MAX_CYC
) (
    // Clock and reset.
    input  wire logic              clock_in,
    input  wire logic              sys_rst_in,
    // Controller pins.
    input  wire logic              sleep_request_low_in,
    input  wire logic              fault_recovery_select_in,
    // Analog monitor flags.
    input  wire logic              supply_lockout_in,
    input  wire logic              pump_undervoltage_in,
    input  wire logic              logic_undervoltage_in,
    input  wire logic              thermal_shutdown_in,
    input  wire logic [NUM_BR-1:0] hs_limit_in,
    input  wire logic [NUM_BR-1:0] ls_limit_in,
    // Enables to the power stage.
    output logic      [NUM_BR-1:0] bridge_enable_out,
    output logic                   pump_enable_out,
    output logic                   regulator_enable_out,
    output logic                   serial_enable_out,
    output logic                   ready_out,
    // Open-drain fault pin, enable low while pulling the line low.
    output logic                   fault_indicator_low_out,
    output logic                   fault_indicator_low_oe_n_out
);
    import dfs_pkg::*;

    if (NUM_BR < 1 || PULSE_MIN_CYC < 1 || PULSE_MAX_CYC <= PULSE_MIN_CYC ||
        SLEEP_ENTRY_CYC < 1 || WAKEUP_CYC < 1 || WAKEUP_CYC >= 2**CNT_W ||
        SLEEP_ENTRY_CYC >= 2**CNT_W || PULSE_MAX_CYC >= 2**CNT_W) begin : g_bad_params
        $error("dfs_supervisor: parameters out of range");
    end

    // Logic undervoltage acts as a reset of all state.
    logic              rst_all;
    assign rst_all = sys_rst_in | logic_undervoltage_in; // see R5

    // Low time measurement of the sleep input and pulse decode.
    logic [CNT_W-1:0]  low_cnt_q, low_cnt_d;
    logic              sleep_q, sleep_d;
    logic              clear_pulse;

    always_comb begin
        low_cnt_d = low_cnt_q;
        sleep_d   = sleep_request_low_in;
        if (!sleep_request_low_in) begin
            if (low_cnt_q < CNT_W'(PULSE_MAX_CYC)) begin
                low_cnt_d = low_cnt_q + 1'b1;
            end
        end else begin
            low_cnt_d = '0;
        end
    end

    // A rising edge after 20 to 120 us low clears latched faults.
    assign clear_pulse = sleep_request_low_in && !sleep_q &&
                         low_cnt_q > CNT_W'(PULSE_MIN_CYC) &&
                         low_cnt_q < CNT_W'(PULSE_MAX_CYC); // see R19, R20

    always_ff @(posedge clock_in or posedge rst_all) begin
        if (rst_all) begin
            low_cnt_q <= '0;
            sleep_q   <= 1'b1;
        end else begin
            low_cnt_q <= low_cnt_d;
            sleep_q   <= sleep_d;
        end
    end

    // Thermal fault state.
    logic thermal_q, thermal_d;

    always_comb begin
        thermal_d = thermal_q;
        if (thermal_shutdown_in) begin
            thermal_d = 1'b1; // see R11
        end else if (fault_recovery_select_in) begin
            thermal_d = 1'b0; // see R13
        end else if (clear_pulse) begin
            thermal_d = 1'b0; // see R12
        end
    end

    always_ff @(posedge clock_in or posedge rst_all) begin
        if (rst_all) begin
            thermal_q <= 1'b0;
        end else begin
            thermal_q <= thermal_d;
        end
    end

    // Per-bridge overcurrent.
    logic [NUM_BR-1:0] oc_fault;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_BR; gi++) begin : g_oc
            dfs_oc_channel #(
                .QUAL_CYC  (QUAL_CYC),
                .RETRY_CYC (RETRY_CYC)
            ) u_oc (
                .clock_in      (clock_in),
                .sys_rst_in    (rst_all),
                .hs_limit_in   (hs_limit_in[gi]),
                .ls_limit_in   (ls_limit_in[gi]),
                .auto_retry_in (fault_recovery_select_in),
                .clear_in      (clear_pulse),
                .fault_out     (oc_fault[gi])
            );
        end
    endgenerate

    // Power mode machine.
    dfs_pwr_type       pwr_q, pwr_d;
    logic [CNT_W-1:0]  tmr_q, tmr_d;

    always_comb begin
        pwr_d = pwr_q;
        tmr_d = tmr_q;
        case (pwr_q)
            PWR_RUN: begin
                tmr_d = '0;
                if (!sleep_request_low_in) begin
                    pwr_d = PWR_ENTER;
                end
            end
            PWR_ENTER: begin
                if (sleep_request_low_in) begin
                    pwr_d = PWR_RUN; // a reset pulse leaves the blocks running, see R21
                    tmr_d = '0;
                end else if (tmr_q >= CNT_W'(SLEEP_ENTRY_CYC - 1)) begin
                    pwr_d = PWR_SLEEP; // see R16
                    tmr_d = '0;
                end else begin
                    tmr_d = tmr_q + 1'b1;
                end
            end
            PWR_SLEEP: begin
                tmr_d = '0;
                if (sleep_request_low_in) begin
                    pwr_d = PWR_WAKE; // see R17
                end
            end
            PWR_WAKE: begin
                if (!sleep_request_low_in) begin
                    pwr_d = PWR_SLEEP;
                    tmr_d = '0;
                end else if (tmr_q >= CNT_W'(WAKEUP_CYC - 1)) begin
                    pwr_d = PWR_RUN; // see R17
                    tmr_d = '0;
                end else begin
                    tmr_d = tmr_q + 1'b1;
                end
            end
            default: begin
                pwr_d = PWR_SLEEP;
                tmr_d = '0;
            end
        endcase
    end

    always_ff @(posedge clock_in or posedge rst_all) begin
        if (rst_all) begin
            pwr_q <= PWR_WAKE;
            tmr_q <= '0;
        end else begin
            pwr_q <= pwr_d;
            tmr_q <= tmr_d;
        end
    end

    // Output enables, registered.
    logic              awake;
    logic              operating;
    logic [NUM_BR-1:0] bridge_d;
    logic              pump_d;
    logic              fault_d;
    logic [NUM_BR-1:0] bridge_q;
    logic              pump_q, reg_q, ser_q, ready_q, fault_q;

    assign awake     = (pwr_q != PWR_SLEEP); // see R15
    assign operating = (pwr_q == PWR_RUN || pwr_q == PWR_ENTER) && !supply_lockout_in; // see R18

    always_comb begin
        // Global faults: motor supply (R1), pump (R3), thermal (R11).
        if (operating && !pump_undervoltage_in && !thermal_q) begin
            bridge_d = ~oc_fault; // see R2, R4, R7
        end else begin
            bridge_d = '0; // see R1, R3, R11
        end
        pump_d  = awake && !supply_lockout_in && !thermal_q; // see R1, R3, R11
        fault_d = supply_lockout_in | pump_undervoltage_in | thermal_q | (|oc_fault); // see R22, R14
    end

    always_ff @(posedge clock_in or posedge rst_all) begin
        if (rst_all) begin
            bridge_q <= '0;
            pump_q   <= 1'b0;
            reg_q    <= 1'b0;
            ser_q    <= 1'b0;
            ready_q  <= 1'b0;
            fault_q  <= 1'b0; // see R5, R14
        end else begin
            bridge_q <= bridge_d;
            pump_q   <= pump_d;
            reg_q    <= awake;
            ser_q    <= awake;
            ready_q  <= operating;
            fault_q  <= fault_d;
        end
    end

    assign bridge_enable_out            = bridge_q;
    assign pump_enable_out              = pump_q;
    assign regulator_enable_out         = reg_q;
    assign serial_enable_out            = ser_q;
    assign ready_out                    = ready_q;
    assign fault_indicator_low_out      = 1'b0;
    assign fault_indicator_low_oe_n_out = ~fault_q;

    chk_uv_outputs: assert property (@(posedge clock_in) disable iff (rst_all) // see R1
        supply_lockout_in |=> (bridge_q == '0) && !pump_q && fault_q) else $error("supply_lockout");
    chk_pump_undervoltage_pump: assert property (@(posedge clock_in) disable iff (rst_all) // see R3
        (pump_undervoltage_in && awake && !supply_lockout_in && !thermal_q)
        |=> pump_q && fault_q && bridge_q == '0) else $error("pump_undervoltage");
    chk_pump_undervoltage_release: assert property (@(posedge clock_in) disable iff (rst_all) // see R4
        (!pump_undervoltage_in && !supply_lockout_in && !thermal_q && oc_fault == '0)
        |=> !fault_q) else $error("fault not released");
    chk_thermal_off: assert property (@(posedge clock_in) disable iff (rst_all) // see R11
        thermal_q |=> bridge_q == '0 && !pump_q && fault_q) else $error("thermal");
    chk_thermal_latch: assert property (@(posedge clock_in) disable iff (rst_all) // see R12
        (thermal_q && !fault_recovery_select_in && !clear_pulse) |=> thermal_q)
        else $error("thermal latch lost");
    chk_sleep_delay: assert property (@(posedge clock_in) disable iff (rst_all) // see R16
        (pwr_q == PWR_RUN && !sleep_request_low_in) ##1 (!sleep_request_low_in)[*2]
        |-> pwr_q != PWR_SLEEP) else $error("sleep too early");
    chk_sleep_off: assert property (@(posedge clock_in) disable iff (rst_all) // see R15
        (pwr_q == PWR_SLEEP) |=> !pump_q && !reg_q && !ser_q && bridge_q == '0)
        else $error("sleep outputs");
    chk_oc_bridge: assert property (@(posedge clock_in) disable iff (rst_all) // see R7
        (|oc_fault) |=> fault_q && ((bridge_q & $past(oc_fault)) == '0))
        else $error("oc bridge");
    chk_pulse_clear: assert property (@(posedge clock_in) disable iff (rst_all) // see R19
        (clear_pulse && !thermal_shutdown_in) |=> !thermal_q) else $error("clear");
    cov_pulse: cover property (@(posedge clock_in) disable iff (rst_all) clear_pulse);
    cov_sleep: cover property (@(posedge clock_in) disable iff (rst_all) pwr_q == PWR_SLEEP);
    cov_wake: cover property (@(posedge clock_in) disable iff (rst_all)
        pwr_q == PWR_WAKE ##1 pwr_q == PWR_RUN);
endmodule
